// File: hw/clnp_fifo.sv
`timescale 1ns/10ps
module clnp_fifo #(
	parameter int W = 10,
	parameter int D = 8
) (
	// Clock, reset and enable
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic         ce,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW:0]  wr_ff;
	logic [AW:0]  rd_ff;
	logic         push;
	logic         pop;

	assign in_ready  = (wr_ff - rd_ff) != (AW+1)'(D);
	assign out_valid = wr_ff != rd_ff;
	assign out_data  = mem[rd_ff[AW-1:0]];
	assign push      = ce && in_valid && in_ready;
	assign pop       = ce && out_valid && out_ready;

	always_ff @(posedge hclk) begin
		if (push) begin
			mem[wr_ff[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ff <= '0;
		end else if (push) begin
			wr_ff <= wr_ff + 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_ff <= '0;
		end else if (pop) begin
			rd_ff <= rd_ff + 1'b1;
		end
	end
endmodule : clnp_fifo

// File: hw/clnp_host.sv
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/10ps
module clnp_host #(
	parameter int DEPTH = clnp_pkg::CLNP_FIFO_DEPTH
) (
	// Clock, reset, enable
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                ce,
	// AHB-Lite slave
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic      [31:0]         hrdata,
	output logic                     hreadyout,
	output logic                     hresp,
	// Display and shared bus pins
	output logic                     disp_strobe,
	output logic                     disp_reg_select,
	output logic                     disp_dir,
	output logic      [3:0]          shared_data_hi_nibble_o,
	output logic      [3:0]          shared_data_hi_nibble_oe_n,
	input  wire logic [3:0]          shared_data_hi_nibble_i,
	// Flash strap levels
	input  wire logic                flash_chip_en_n,
	input  wire logic                flash_byte_mode_n
);
	import clnp_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_HIGH,
		ST_LOW,
		ST_DONE
	} clnp_state_t;

	// ****************************************
	// Bus slave
	// ****************************************
	logic        ap_wr_ff;
	logic        ap_rd_ff;
	logic [7:0]  ap_addr_ff;
	logic [31:0] hrdata_ff;
	logic [15:0] timing_ff;
	logic [7:0]  rdata_ff;
	logic        rvalid_ff;
	logic        busy_ff;
	logic        blocked_ff;
	logic        push_valid;
	logic        fifo_ready;
	logic        fifo_valid;
	logic        take;
	logic [CLNP_CMD_W-1:0] fifo_q;
	clnp_cmd_t   cur_ff;
	clnp_cmd_t   head;
	logic        rd_ok;
	logic        rdata_pop;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_ff   <= 1'b0;
			ap_rd_ff   <= 1'b0;
			ap_addr_ff <= 8'h00;
		end else if (ce) begin
			ap_wr_ff   <= hsel && hready && htrans[1] && hwrite;
			ap_rd_ff   <= hsel && hready && htrans[1] && !hwrite;
			ap_addr_ff <= haddr[7:0];
		end
	end

	assign push_valid = ap_wr_ff && (ap_addr_ff == CLNP_REG_CMD);
	assign rdata_pop  = ap_rd_ff && (ap_addr_ff == CLNP_REG_RDATA);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timing_ff <= CLNP_TIMING_RST;
		end else if (ce && ap_wr_ff && ap_addr_ff == CLNP_REG_TIMING) begin
			timing_ff <= (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (ce) begin
			if (hsel && hready && htrans[1] && !hwrite) begin
				if (haddr[7:0] == CLNP_REG_STATUS) begin
					hrdata_ff <= {28'h000_0000, blocked_ff, rvalid_ff, !fifo_ready, busy_ff};
				end else if (haddr[7:0] == CLNP_REG_RDATA) begin
					hrdata_ff <= {24'h00_0000, rdata_ff};
				end else if (haddr[7:0] == CLNP_REG_TIMING) begin
					hrdata_ff <= {16'h0000, timing_ff};
				end else begin
					hrdata_ff <= 32'h0000_0000;
				end
			end
		end
	end

	// ****************************************
	// Command queue
	// ****************************************
	clnp_fifo #(
		.W (CLNP_CMD_W),
		.D (DEPTH)
	) u_fifo (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.ce        (ce),
		.in_valid  (push_valid),
		.in_ready  (fifo_ready),
		.in_data   (hwdata[CLNP_CMD_W-1:0]),
		.out_valid (fifo_valid),
		.out_ready (take),
		.out_data  (fifo_q)
	);

	assign head = clnp_cmd_t'(fifo_q);

	// ****************************************
	// Strap and read data synchronisers
	// ****************************************
	logic [1:0] ce_n_sync_ff;
	logic [1:0] byte_n_sync_ff;
	logic [3:0] din_s1_ff;
	logic [3:0] din_s2_ff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ce_n_sync_ff   <= 2'b00;
			byte_n_sync_ff <= 2'b11;
			din_s1_ff      <= 4'h0;
			din_s2_ff      <= 4'h0;
		end else if (ce) begin
			ce_n_sync_ff   <= {ce_n_sync_ff[0], flash_chip_en_n};
			byte_n_sync_ff <= {byte_n_sync_ff[0], flash_byte_mode_n};
			din_s1_ff      <= shared_data_hi_nibble_i;
			din_s2_ff      <= din_s1_ff;
		end
	end

	// Reading allowed only when flash is off or in byte mode
	assign rd_ok = ce_n_sync_ff[1] || !byte_n_sync_ff[1]; // [RL7] [RL9] [RL13]

	// ****************************************
	// Nibble sequencer
	// ****************************************
	clnp_state_t state_ff;
	logic [15:0] cnt_ff;
	logic        half_ff;
	logic [3:0]  hi_nib_ff;
	logic        cnt_done;

	assign cnt_done = cnt_ff == 16'h0000;
	assign take     = (state_ff == ST_IDLE) && fifo_valid && (!head.rd || rd_ok);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= ST_IDLE;
			cnt_ff   <= 16'h0000;
			half_ff  <= 1'b0;
			cur_ff   <= '0;
		end else if (ce) begin
			case (state_ff)
				ST_IDLE: begin
					if (take) begin
						cur_ff   <= head;
						half_ff  <= 1'b0; // [RL12]
						cnt_ff   <= timing_ff;
						state_ff <= ST_SETUP;
					end
				end
				ST_SETUP: begin
					cnt_ff <= cnt_ff - 16'h0001;
					if (cnt_done) begin
						cnt_ff   <= timing_ff; // [RL11]
						state_ff <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					cnt_ff <= cnt_ff - 16'h0001;
					if (cnt_done) begin
						cnt_ff   <= timing_ff;
						state_ff <= ST_LOW;
					end
				end
				ST_LOW: begin
					cnt_ff <= cnt_ff - 16'h0001;
					if (cnt_done) begin
						if (!half_ff) begin
							half_ff  <= 1'b1; // [RL12]
							cnt_ff   <= timing_ff;
							state_ff <= ST_SETUP;
						end else begin
							state_ff <= ST_DONE;
						end
					end
				end
				ST_DONE: begin
					state_ff <= ST_IDLE;
				end
				default: begin
					state_ff <= ST_IDLE;
				end
			endcase
		end
	end

	// Read nibble taken at end of strobe high; needs timing of 3 or more for synchroniser lag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hi_nib_ff <= 4'h0;
			rdata_ff  <= 8'h00;
			rvalid_ff <= 1'b0;
		end else if (ce) begin
			if (state_ff == ST_HIGH && cnt_done && cur_ff.rd) begin
				if (!half_ff) begin
					hi_nib_ff <= din_s2_ff;
				end else begin
					rdata_ff  <= {hi_nib_ff, din_s2_ff}; // [RL12] [RL2]
					rvalid_ff <= 1'b1;
				end
			end else if (rdata_pop) begin
				rvalid_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_ff    <= 1'b0;
			blocked_ff <= 1'b0;
		end else if (ce) begin
			busy_ff    <= (state_ff != ST_IDLE) || fifo_valid;
			blocked_ff <= fifo_valid && head.rd && !rd_ok;
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			disp_strobe                <= 1'b0;
			disp_reg_select            <= 1'b0;
			disp_dir                   <= 1'b0;
			shared_data_hi_nibble_o    <= 4'h0;
			shared_data_hi_nibble_oe_n <= 4'hF;
		end else if (ce) begin
			disp_strobe     <= (state_ff == ST_HIGH); // [RL1]
			disp_reg_select <= cur_ff.rs; // [RL2]
			disp_dir        <= (state_ff != ST_IDLE) && (state_ff != ST_DONE)
			                   && cur_ff.rd; // [RL3] [RL6]
			shared_data_hi_nibble_o <= half_ff ? cur_ff.data[3:0]
			                                   : cur_ff.data[7:4]; // [RL4] [RL5] [RL12]
			if ((state_ff == ST_IDLE) || (state_ff == ST_DONE) || cur_ff.rd) begin
				shared_data_hi_nibble_oe_n <= 4'hF; // [RL13] [RL8]
			end else begin
				shared_data_hi_nibble_oe_n <= 4'h0; // [RL10]
			end
		end
	end
endmodule : clnp_host

// File: hw/clnp_pkg.sv
// Summary of operation
// (RL1) The strobe to the display idles low and goes high once for each nibble transfer.
// (RL2) Register select high moves display data; low writes an instruction or reads the busy flag.
// (RL3) Direction low makes the display accept data; high makes it present data.
// (RL4) The display is driven over a 4-bit path only.
// (RL5) Display bits 7 to 4 ride on the shared bus lines 11 to 8.
// (RL6) The display drives the shared lines whenever its direction line is high.
// (RL7) With the flash chip enable high the display may be read and written freely.
// (RL8) With the direction line low the flash may be used freely.
// (RL9) With the flash in byte mode both display and flash may be used at once.
// (RL10) Writing only and never reading the display is the recommended use.
// (RL11) Transfer sequencing runs far slower than the system clock.
// (RL12) Each byte goes as two nibbles, upper first, then lower.
// (RL13) The host releases the shared lines while direction is high, and never reads while
// the flash is enabled in word mode.
package clnp_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0]  CLNP_REG_CMD    = 8'h00;
	localparam logic [7:0]  CLNP_REG_STATUS = 8'h04;
	localparam logic [7:0]  CLNP_REG_RDATA  = 8'h08;
	localparam logic [7:0]  CLNP_REG_TIMING = 8'h0C;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int          CLNP_CMD_RS_BIT   = 8;
	localparam int          CLNP_CMD_READ_BIT = 9;
	localparam int          CLNP_ST_BUSY_BIT  = 0;
	localparam int          CLNP_ST_FULL_BIT  = 1;
	localparam int          CLNP_ST_RVAL_BIT  = 2;
	localparam int          CLNP_ST_BLK_BIT   = 3;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [15:0] CLNP_TIMING_RST   = 16'h0032;
	localparam int          CLNP_CLK_MHZ      = 100;
	localparam int          CLNP_STROBE_NS    = 500;
	localparam int          CLNP_STROBE_CYC   = (CLNP_STROBE_NS * CLNP_CLK_MHZ + 999) / 1000;
	localparam int          CLNP_FIFO_DEPTH   = 8;
	localparam int          CLNP_CMD_W        = 10;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic       rd;
		logic       rs;
		logic [7:0] data;
	} clnp_cmd_t;

	typedef struct packed {
		logic       strobe;
		logic       reg_select;
		logic       dir;
		logic [3:0] data_o;
		logic [3:0] data_oe_n;
	} clnp_pins_t;

endpackage : clnp_pkg

// File: testbench/clnp_disp_model.sv
`timescale 1ns/10ps
module clnp_disp_model (
	// Control pins
	input wire logic       strobe,
	input wire logic       rs,
	input wire logic       dir,
	// Data lines
	input wire logic [3:0] bus,
	output logic     [3:0] q,
	output logic           drv
);
	logic [4:0] got[$];
	logic [7:0] rd_byte = 8'h00;
	logic       hi      = 1'b1;
	logic [7:0] src;
	initial q = 4'h0;
	assign drv = dir;
	// Busy flag clear, address 0x15
	assign src = rs ? rd_byte : 8'h15;
	always @(negedge strobe) begin
		if (!dir) begin
			got.push_back({rs, bus});
		end
	end
	always @(posedge strobe) begin
		if (dir) begin
			q  <= hi ? src[7:4] : src[3:0];
			hi <= ~hi;
		end
	end
endmodule : clnp_disp_model

// File: testbench/clnp_host_sva.sv
`timescale 1ns/10ps
module clnp_host_sva (
	// Clock and reset
	input wire logic       hclk,
	input wire logic       hresetn,
	// Display pins
	input wire logic       disp_strobe,
	input wire logic       disp_reg_select,
	input wire logic       disp_dir,
	input wire logic [3:0] shared_data_hi_nibble_o,
	input wire logic [3:0] shared_data_hi_nibble_oe_n,
	// Straps and bus
	input wire logic       flash_chip_en_n,
	input wire logic       flash_byte_mode_n,
	input wire logic       hreadyout,
	input wire logic       hresp
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_high; disp_strobe [*2]; endsequence
	sequence s_low; !disp_strobe [*2]; endsequence
	AST_RELEASE: assert property (disp_dir |-> shared_data_hi_nibble_oe_n == 4'hF)
		else $error("bus driven during read");
	AST_DRIVE: assert property (disp_strobe && !disp_dir |-> shared_data_hi_nibble_oe_n == 4'h0)
		else $error("nibble not driven in write");
	AST_WIDTH: assert property ($rose(disp_strobe) |-> s_high)
		else $error("strobe pulse too short");
	AST_GAP: assert property ($fell(disp_strobe) |-> s_low)
		else $error("strobe gap too short");
	AST_SETUP: assert property ($rose(disp_strobe) |-> $stable(disp_reg_select) && $stable(disp_dir)
		&& (disp_dir || $past(shared_data_hi_nibble_oe_n) == 4'h0))
		else $error("no setup before strobe");
	AST_HOLD: assert property (disp_strobe && $past(disp_strobe) |-> $stable(disp_reg_select)
		&& $stable(disp_dir) && (disp_dir || $stable(shared_data_hi_nibble_o)))
		else $error("pins moved during strobe");
	AST_GATE: assert property ($rose(disp_dir) |-> flash_chip_en_n || !flash_byte_mode_n)
		else $error("read while flash word mode");
	AST_BUS_OK: assert property (hreadyout && !hresp)
		else $error("bus wait or error");
endmodule : clnp_host_sva

bind clnp_host clnp_host_sva u_clnp_host_sva (
	.hclk                       (hclk),
	.hresetn                    (hresetn),
	.disp_strobe                (disp_strobe),
	.disp_reg_select            (disp_reg_select),
	.disp_dir                   (disp_dir),
	.shared_data_hi_nibble_o    (shared_data_hi_nibble_o),
	.shared_data_hi_nibble_oe_n (shared_data_hi_nibble_oe_n),
	.flash_chip_en_n            (flash_chip_en_n),
	.flash_byte_mode_n          (flash_byte_mode_n),
	.hreadyout                  (hreadyout),
	.hresp                      (hresp)
);

// File: testbench/tb_char_lcd_nibble_port.sv
`timescale 1ns/10ps
module tb_char_lcd_nibble_port;
	import clnp_pkg::*;
	logic        hclk    = 1'b0;
	logic        hresetn = 1'b0;
	logic [31:0] haddr   = 32'h0000_0000;
	logic [31:0] hwdata  = 32'h0000_0000;
	logic [1:0]  htrans  = 2'h0;
	logic        hwrite  = 1'b0;
	logic        fce_n   = 1'b0;
	logic        fbyte_n = 1'b1;
	logic        ce      = 1'b1;
	logic [31:0] hrdata, r;
	logic        hreadyout, hresp, strobe, rs, dir, mdrv;
	logic [3:0]  d_o, d_oe_n, mq, lvl;
	int          fails      = 0;
	int          num_checks = 0;
	always #5 hclk = ~hclk;
	// Undriven lines show the inverse of the display model's last output nibble
	assign lvl = (d_oe_n == 4'h0) ? d_o : (mdrv ? mq : ~mq);
	clnp_host u_clnp_host (
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .disp_strobe(strobe),
		.disp_reg_select(rs), .disp_dir(dir), .shared_data_hi_nibble_o(d_o),
		.shared_data_hi_nibble_oe_n(d_oe_n), .shared_data_hi_nibble_i(lvl),
		.flash_chip_en_n(fce_n), .flash_byte_mode_n(fbyte_n));
	clnp_disp_model u_clnp_disp_model (
		.strobe(strobe), .rs(rs), .dir(dir), .bus(lvl), .q(mq), .drv(mdrv));
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			summarize();
		end
	endtask : rdy
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr  <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		rdy();
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		r = hrdata;
	endtask : ahb
	task automatic wait_idle();
		int n, z;
		z = 0;
		ahb(1'b0, CLNP_REG_STATUS, 32'h0000_0000);
		for (n = 0; n < 2000 && z < 2; n++) begin
			ahb(1'b0, CLNP_REG_STATUS, 32'h0000_0000);
			z = (r[CLNP_ST_BUSY_BIT] === 1'b0) ? z + 1 : 0;
		end
		if (z < 2) begin
			fails++;
			summarize();
		end
	endtask : wait_idle
	task automatic t_regs();
		ahb(1'b0, CLNP_REG_TIMING, 32'h0000_0000);
		chk("timing", {16'h0000, CLNP_TIMING_RST}, r);
		ahb(1'b0, CLNP_REG_STATUS, 32'h0000_0000);
		chk("status", 32'h0000_0000, r);
		ahb(1'b1, 8'h10, 32'hFFFF_FFFF);
		ahb(1'b0, 8'h10, 32'h0000_0000);
		chk("unmapped", 32'h0000_0000, r);
		ahb(1'b1, CLNP_REG_TIMING, 32'h0000_0000);
		ahb(1'b0, CLNP_REG_TIMING, 32'h0000_0000);
		chk("timing zero", 32'h0000_0001, r);
		ahb(1'b1, CLNP_REG_TIMING, 32'h0000_0003);
		$display("test regs done");
	endtask : t_regs
	task automatic t_write();
		logic [19:0] ew;
		ew = {5'h1A, 5'h15, 5'h02, 5'h08};
		u_clnp_disp_model.got.delete();
		ahb(1'b1, CLNP_REG_CMD, 32'h0000_01A5);
		ahb(1'b1, CLNP_REG_CMD, 32'h0000_0028);
		wait_idle();
		chk("count", 32'h0000_0004, 32'(u_clnp_disp_model.got.size()));
		for (int i = 0; i < 4; i++) begin
			chk("nibble", 32'(ew[19-5*i -: 5]), 32'(u_clnp_disp_model.got[i]));
		end
		$display("test write done");
	endtask : t_write
	task automatic t_read();
		u_clnp_disp_model.rd_byte = 8'h3C;
		ahb(1'b1, CLNP_REG_CMD, 32'h0000_0300);
		repeat (4) ahb(1'b0, CLNP_REG_STATUS, 32'h0000_0000);
		chk("blocked", 32'h0000_0001, 32'(r[CLNP_ST_BLK_BIT]));
		chk("dir", 32'h0000_0000, 32'(dir));
		fbyte_n <= 1'b0;
		wait_idle();
		chk("rvalid", 32'h0000_0001, 32'(r[CLNP_ST_RVAL_BIT]));
		ahb(1'b0, CLNP_REG_RDATA, 32'h0000_0000);
		chk("rdata", 32'h0000_003C, r);
		ahb(1'b0, CLNP_REG_STATUS, 32'h0000_0000);
		chk("rvalid clr", 32'h0000_0000, 32'(r[CLNP_ST_RVAL_BIT]));
		fce_n   <= 1'b1;
		fbyte_n <= 1'b1;
		ahb(1'b1, CLNP_REG_CMD, 32'h0000_0200);
		wait_idle();
		ahb(1'b0, CLNP_REG_RDATA, 32'h0000_0000);
		chk("busy flag", 32'h0000_0015, r);
		fce_n <= 1'b0;
		$display("test read done");
	endtask : t_read
	task automatic t_fifo();
		ahb(1'b1, CLNP_REG_TIMING, 32'h0000_0028);
		u_clnp_disp_model.got.delete();
		for (int i = 0; i < 10; i++) begin
			ahb(1'b1, CLNP_REG_CMD, 32'(i));
		end
		ahb(1'b0, CLNP_REG_STATUS, 32'h0000_0000);
		chk("full", 32'h0000_0001, 32'(r[CLNP_ST_FULL_BIT]));
		wait_idle();
		chk("kept", 32'h0000_0012, 32'(u_clnp_disp_model.got.size()));
		chk("last", 32'h0000_0008, 32'(u_clnp_disp_model.got[17]));
		$display("test fifo done");
	endtask : t_fifo
	task automatic t_freeze();
		int n;
		u_clnp_disp_model.got.delete();
		ahb(1'b1, CLNP_REG_CMD, 32'h0000_0047);
		n = 0;
		while (strobe !== 1'b1 && n < 500) begin
			@(posedge hclk);
			n++;
		end
		if (n >= 500) begin
			fails++;
			summarize();
		end
		ce <= 1'b0;
		repeat (60) @(posedge hclk);
		chk("frozen strobe", 32'h0000_0001, 32'(strobe));
		chk("frozen count", 32'h0000_0000, 32'(u_clnp_disp_model.got.size()));
		ce <= 1'b1;
		wait_idle();
		chk("thaw count", 32'h0000_0002, 32'(u_clnp_disp_model.got.size()));
		chk("thaw nibble", 32'h0000_0007, 32'(u_clnp_disp_model.got[1]));
		$display("test freeze done");
	endtask : t_freeze
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_write();
		t_read();
		t_fifo();
		t_freeze();
		summarize();
	end
	initial begin
		repeat (100000) @(posedge hclk);
		fails++;
		summarize();
	end
endmodule : tb_char_lcd_nibble_port
